// ===== dcap_cache.sv
`timescale 1ns/1ns
`include "dcap_consts.svh"
module dcap_cache
  import dcap_pkg::*;
#(
  parameter int INDEX_W = `DCAP_INDEX_W,
  parameter int REFILL_WORDS = `DCAP_REFILL_MAX
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // load/store request
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_cacheable,
  input wire logic i_write_back,
  input wire logic [3:0] i_byte_en,
  input wire logic [`DCAP_ADDR_W-1:0] i_addr,
  input wire logic [`DCAP_DATA_W-1:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic o_hit,
  output logic [`DCAP_DATA_W-1:0] o_rdata,
  // line invalidate from software
  input wire logic i_inval,
  input wire logic [INDEX_W-1:0] i_inval_index,
  // external memory
  output logic o_mem_req,
  output logic o_mem_write,
  output logic [3:0] o_mem_byte_en,
  output logic [`DCAP_ADDR_W-1:0] o_mem_addr,
  output logic [`DCAP_DATA_W-1:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [`DCAP_DATA_W-1:0] i_mem_rdata
);
  localparam int LINES = 1 << INDEX_W;
  localparam int TW = `DCAP_ADDR_W - `DCAP_INDEX_LSB - INDEX_W;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [TW-1:0] tag_reg [LINES];
  logic [`DCAP_DATA_W-1:0] data_reg [LINES];
  logic valid_reg [LINES];
  logic dirty_reg [LINES];

  dcap_state_type state_reg;
  logic [`DCAP_ADDR_W-1:0] addr_reg;
  logic [`DCAP_DATA_W-1:0] wdata_reg;
  logic [3:0] be_reg;
  logic wb_reg;
  logic write_reg;
  logic cached_reg;
  logic [`DCAP_CNT_W-1:0] cnt_reg;

  function automatic logic [INDEX_W-1:0] idx_of(input logic [`DCAP_ADDR_W-1:0] a);
    idx_of = a[`DCAP_INDEX_LSB +: INDEX_W];
  endfunction

  function automatic logic [TW-1:0] tag_of(input logic [`DCAP_ADDR_W-1:0] a);
    tag_of = a[`DCAP_ADDR_W-1 -: TW];
  endfunction

  function automatic logic [`DCAP_DATA_W-1:0] merge(input logic [`DCAP_DATA_W-1:0] old,
      input logic [`DCAP_DATA_W-1:0] nw, input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    merge = old;
  endfunction

  // ----------------------------------------
  // lookup
  // ----------------------------------------
  // single-cycle lookup
  wire [INDEX_W-1:0] req_idx = idx_of(i_addr);
  wire [INDEX_W-1:0] cur_idx = idx_of(addr_reg);
  wire req_hit = valid_reg[req_idx] && (tag_reg[req_idx] == tag_of(i_addr));
  wire cur_hit = valid_reg[cur_idx] && (tag_reg[cur_idx] == tag_of(addr_reg));
  wire full_word = (i_byte_en == 4'hf);
  wire idle = (state_reg == DCAP_IDLE);
  wire take = idle && i_req;
  // refill block base and current fill address
  wire [`DCAP_ADDR_W-1:0] blk_base = addr_reg & ~(`DCAP_ADDR_W'(REFILL_WORDS * 4 - 1));
  wire [`DCAP_ADDR_W-1:0] fill_addr = blk_base + {{(`DCAP_ADDR_W-`DCAP_CNT_W-2){1'b0}},
      cnt_reg, 2'b00};
  wire [INDEX_W-1:0] fill_idx = idx_of(fill_addr);
  wire victim_dirty = valid_reg[fill_idx] && dirty_reg[fill_idx] &&
      (tag_reg[fill_idx] != tag_of(fill_addr));
  wire [`DCAP_ADDR_W-1:0] victim_addr = {tag_reg[fill_idx], fill_idx, 2'b00};
  wire last_fill = (cnt_reg == `DCAP_CNT_W'(REFILL_WORDS - 1));
  wire [`DCAP_DATA_W-1:0] merged = merge(data_reg[cur_idx], wdata_reg, be_reg);
  wire [INDEX_W-1:0] wr_idx = idx_of(i_addr);
  wire mem_pending = o_mem_req && !i_mem_ack;

  // ----------------------------------------
  // control
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_reg <= DCAP_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      be_reg <= 4'h0;
      wb_reg <= 1'b0;
      write_reg <= 1'b0;
      cached_reg <= 1'b0;
      cnt_reg <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_hit <= 1'b0;
      o_rdata <= '0;
      o_mem_req <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_byte_en <= 4'h0;
      o_mem_addr <= '0;
      o_mem_wdata <= '0;
    end else begin
      o_done <= 1'b0;
      o_hit <= 1'b0;
      if (i_mem_ack) begin
        o_mem_req <= 1'b0;
      end
      unique case (state_reg)
        DCAP_IDLE: begin
          if (take) begin
            addr_reg <= i_addr;
            wdata_reg <= i_wdata;
            be_reg <= i_byte_en;
            wb_reg <= i_write_back;
            write_reg <= i_write;
            cached_reg <= i_cacheable;
            cnt_reg <= '0;
            if (!i_cacheable) begin
              o_busy <= 1'b1;
              o_mem_req <= 1'b1;
              o_mem_write <= i_write;
              o_mem_byte_en <= i_write ? i_byte_en : 4'hf;
              o_mem_addr <= i_addr;
              o_mem_wdata <= i_wdata;
              state_reg <= i_write ? DCAP_MEM_WR : DCAP_UNC_RD;
            end else if (!i_write && req_hit) begin
              o_done <= 1'b1;
              o_hit <= 1'b1;
              o_rdata <= data_reg[req_idx];
            end else if (!i_write) begin
              o_busy <= 1'b1;
              state_reg <= DCAP_FILL;
            end else if (!full_word) begin
              o_busy <= 1'b1;
              state_reg <= DCAP_MERGE;
            end else if (!i_write_back) begin
              o_busy <= 1'b1;
              o_mem_req <= 1'b1;
              o_mem_write <= 1'b1;
              o_mem_byte_en <= 4'hf;
              o_mem_addr <= i_addr;
              o_mem_wdata <= i_wdata;
              state_reg <= DCAP_MEM_WR;
            end else if (valid_reg[req_idx] && dirty_reg[req_idx] && !req_hit) begin
              // dirty victim of a store copied out first
              o_busy <= 1'b1;
              o_mem_req <= 1'b1;
              o_mem_write <= 1'b1;
              o_mem_byte_en <= 4'hf;
              o_mem_addr <= {tag_reg[req_idx], req_idx, 2'b00};
              o_mem_wdata <= data_reg[req_idx];
              state_reg <= DCAP_MEM_WR;
            end else begin
              o_done <= 1'b1;
              o_hit <= req_hit;
            end
          end
        end
        DCAP_MERGE: begin
          o_hit <= cur_hit;
          if (cur_hit && wb_reg) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state_reg <= DCAP_IDLE;
          end else begin
            // miss or write-through: memory gets the bytes
            o_mem_req <= 1'b1;
            o_mem_write <= 1'b1;
            o_mem_byte_en <= be_reg;
            o_mem_addr <= addr_reg;
            o_mem_wdata <= wdata_reg;
            state_reg <= DCAP_MEM_WR;
          end
        end
        DCAP_FILL: begin
          if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_byte_en <= 4'hf;
            if (victim_dirty) begin
              o_mem_write <= 1'b1;
              o_mem_addr <= victim_addr;
              o_mem_wdata <= data_reg[fill_idx];
              state_reg <= DCAP_WBACK;
            end else begin
              o_mem_write <= 1'b0;
              o_mem_addr <= fill_addr;
            end
          end else if (i_mem_ack) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (fill_addr == addr_reg) begin
              o_rdata <= i_mem_rdata;
            end
            if (last_fill) begin
              o_busy <= 1'b0;
              o_done <= 1'b1;
              state_reg <= DCAP_IDLE;
            end
          end
        end
        DCAP_WBACK: begin
          if (i_mem_ack) begin
            state_reg <= DCAP_FILL;
          end
        end
        DCAP_UNC_RD: begin
          if (i_mem_ack) begin
            o_rdata <= i_mem_rdata;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state_reg <= DCAP_IDLE;
          end
        end
        DCAP_MEM_WR: begin
          if (i_mem_ack) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state_reg <= DCAP_IDLE;
          end
        end
        default: begin
          state_reg <= DCAP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // cache array updates
  // ----------------------------------------
  // no reset of contents; software invalidates
  always_ff @(posedge i_clock) begin
    if (i_inval && idle) begin
      valid_reg[i_inval_index] <= 1'b0;
      dirty_reg[i_inval_index] <= 1'b0;
    end
    if (take && i_cacheable && i_write && full_word && !(i_write_back && mem_pending)) begin
      if (!(i_write_back && valid_reg[wr_idx] && dirty_reg[wr_idx] && !req_hit)) begin
        tag_reg[wr_idx] <= tag_of(i_addr);
        data_reg[wr_idx] <= i_wdata;
        valid_reg[wr_idx] <= 1'b1;
        dirty_reg[wr_idx] <= i_write_back;
      end
    end
    if (state_reg == DCAP_MEM_WR && i_mem_ack && write_reg && wb_reg && cached_reg &&
        be_reg == 4'hf && !cur_hit) begin
      // victim copied out, now store
      tag_reg[cur_idx] <= tag_of(addr_reg);
      data_reg[cur_idx] <= wdata_reg;
      valid_reg[cur_idx] <= 1'b1;
      dirty_reg[cur_idx] <= 1'b1;
    end
    if (state_reg == DCAP_MERGE && cur_hit) begin
      data_reg[cur_idx] <= merged;
      dirty_reg[cur_idx] <= wb_reg | dirty_reg[cur_idx];
    end
    if (state_reg == DCAP_WBACK && i_mem_ack) begin
      dirty_reg[fill_idx] <= 1'b0;
    end
    if (state_reg == DCAP_FILL && o_mem_req && !o_mem_write && i_mem_ack) begin
      tag_reg[fill_idx] <= tag_of(fill_addr);
      data_reg[fill_idx] <= i_mem_rdata;
      valid_reg[fill_idx] <= 1'b1;
      dirty_reg[fill_idx] <= 1'b0;
    end
  end
  // no instruction-side port shares this logic

endmodule // dcap_cache

// ===== dcap_cache_checker.sv
`timescale 1ns/1ns
// ----------
// port checker
// ----------
module dcap_cache_checker (
  // watched ports
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_cacheable,
  input wire logic i_write_back,
  input wire logic [3:0] i_byte_en,
  input wire logic [31:0] i_addr,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_hit,
  input wire logic o_mem_req,
  input wire logic o_mem_write,
  input wire logic [31:0] o_mem_addr
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic taken;
  assign taken = i_req && !o_busy && !o_done && !o_mem_req;
  sequence done_soon;
    ##[0:60] o_done;
  endsequence
  lookup_one_clk_a: assert property (taken && i_cacheable && !i_write
    |=> (o_done && o_hit) || (o_busy && !o_done)) else $error("lookup not one clock");
  unc_mem_rd_a: assert property (taken && !i_cacheable && !i_write
    |=> o_mem_req && !o_mem_write && !o_hit) else $error("uncached load no read");
  unc_no_hit_a: assert property (taken && !i_cacheable
    |=> !o_hit throughout done_soon) else $error("uncached access hit");
  wt_store_mem_a: assert property (taken && i_write && i_cacheable && !i_write_back
    && i_byte_en == 4'hf |=> o_mem_req && o_mem_write && o_mem_addr == $past(i_addr))
    else $error("write-through store not sent");
  unc_store_mem_a: assert property (taken && i_write && !i_cacheable
    |=> o_mem_req && o_mem_write) else $error("uncached store not sent");
  part_extra_clk_a: assert property (taken && i_write && i_byte_en != 4'hf
    |=> !o_done) else $error("partial store too fast");
  wb_full_fast_a: assert property (taken && i_write && i_cacheable && i_write_back
    && i_byte_en == 4'hf |=> (o_done && !o_mem_req) || (o_busy && o_mem_req && o_mem_write))
    else $error("write-back store slow");
  miss_refill_a: assert property (taken && i_cacheable && !i_write ##1 !o_done
    |=> !o_done [*2]) else $error("miss done before refill");
endmodule // dcap_cache_checker
bind dcap_cache dcap_cache_checker u_chk (.i_clock, .i_reset_n, .i_req, .i_write,
  .i_cacheable, .i_write_back, .i_byte_en, .i_addr, .o_busy, .o_done, .o_hit,
  .o_mem_req, .o_mem_write, .o_mem_addr);

// ===== dcap_cache_tb_top.sv
`timescale 1ns/1ns
module dcap_cache_tb_top;
  localparam logic [31:0] PAT = 32'h5a5a_a5a5;
  logic i_clock = 1'b0, i_reset_n = 1'b0, i_req = 1'b0, i_write = 1'b0;
  logic i_cacheable = 1'b0, i_write_back = 1'b0, i_inval = 1'b0, i_mem_ack, o_busy;
  logic o_done, o_hit, o_mem_req, o_mem_write, got_hit;
  logic [3:0] i_byte_en = 4'hf, o_mem_byte_en;
  logic [5:0] i_inval_index = 6'h0;
  logic [31:0] i_addr = 32'h0, i_wdata = 32'h0, o_rdata, o_mem_addr, o_mem_wdata;
  logic [31:0] i_mem_rdata, got;
  int error_cnt = 0, cmp_count = 0, w0;
  dcap_cache u_dut (.i_clock, .i_reset_n, .i_req, .i_write, .i_cacheable, .i_write_back,
    .i_byte_en, .i_addr, .i_wdata, .o_busy, .o_done, .o_hit, .o_rdata, .i_inval,
    .i_inval_index, .o_mem_req, .o_mem_write, .o_mem_byte_en, .o_mem_addr, .o_mem_wdata,
    .i_mem_ack, .i_mem_rdata);
  dcap_mem_model u_mem (.i_clock, .i_req(o_mem_req), .i_write(o_mem_write),
    .i_byte_en(o_mem_byte_en), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  initial forever #25 i_clock = ~i_clock;
  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic access(input logic w, c, wb, input logic [3:0] be, input logic [31:0] a, d);
    i_req = 1'b1;
    i_write = w;
    i_cacheable = c;
    i_write_back = wb;
    i_byte_en = be;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clock);
    i_req = 1'b0;
    for (int n = 0; n < 200 && o_done !== 1'b1; n++) @(negedge i_clock);
    got = o_rdata;
    got_hit = o_hit;
    @(negedge i_clock);
  endtask
  task automatic t_refill();
    int r0 = u_mem.rd_cnt;
    access(0, 1, 0, 4'hf, 32'h1000, 0);
    check("miss hit", got_hit, 0);
    check("miss data", got, 32'h1000 ^ PAT);
    check("refill reads", u_mem.rd_cnt - r0, 4);
    access(0, 1, 0, 4'hf, 32'h100c, 0);
    check("fill hit", got_hit, 1);
    check("fill data", got, 32'h100c ^ PAT);
    access(0, 1, 0, 4'hf, 32'h1100, 0);
    access(0, 1, 0, 4'hf, 32'h1000, 0);
    check("old tag hit", got_hit, 0);
  endtask
  task automatic t_uncached();
    u_mem.mem[32'h1004] = 32'hc0de_0001;
    access(0, 0, 0, 4'hf, 32'h1004, 0);
    check("unc data", got, 32'hc0de_0001);
    access(1, 0, 0, 4'hf, 32'h1004, 32'hbeef_0002);
    check("unc store", u_mem.mem[32'h1004], 32'hbeef_0002);
    access(0, 1, 0, 4'hf, 32'h1004, 0);
    check("cache kept", got, 32'h1004 ^ PAT);
    access(1, 0, 1, 4'hf, 32'h5008, 32'h0bad_0005);
    access(0, 1, 0, 4'hf, 32'h1008, 0);
    check("unc wb store", got_hit, 1);
  endtask
  task automatic t_write_thru();
    w0 = u_mem.wr_cnt;
    access(1, 1, 0, 4'hf, 32'h2020, 32'h1234_5678);
    check("wt mem", u_mem.mem[32'h2020], 32'h1234_5678);
    access(1, 1, 0, 4'h1, 32'h2020, 32'h0000_00ab);
    access(0, 1, 0, 4'hf, 32'h2020, 0);
    check("store hit", got_hit, 1);
    check("merge data", got, 32'h1234_56ab);
    check("merge mem", u_mem.mem[32'h2020], 32'h1234_56ab);
    access(1, 1, 0, 4'h2, 32'h3040, 32'h0000_cd00);
    check("part miss mem", u_mem.mem[32'h3040], 32'h5a5a_cde5);
    access(0, 1, 0, 4'hf, 32'h3040, 0);
    check("no alloc", got_hit, 0);
    access(0, 1, 0, 4'hf, 32'h2120, 0);
    check("wt discard", u_mem.wr_cnt - w0, 3);
  endtask
  task automatic t_write_back();
    w0 = u_mem.wr_cnt;
    access(1, 1, 1, 4'hf, 32'h4080, 32'hfeed_0003);
    check("wb deferred", u_mem.wr_cnt - w0, 0);
    access(0, 1, 0, 4'hf, 32'h4080, 0);
    check("wb data", got, 32'hfeed_0003);
    access(0, 1, 0, 4'hf, 32'h4180, 0);
    check("victim", u_mem.mem[32'h4080], 32'hfeed_0003);
    check("victim count", u_mem.wr_cnt - w0, 1);
    check("new data", got, 32'h4180 ^ PAT);
  endtask
  task automatic t_wb_merge();
    w0 = u_mem.wr_cnt;
    access(1, 1, 1, 4'h4, 32'h4180, 32'h0077_0000);
    check("wb merge hit", got_hit, 1);
    check("wb merge mem", u_mem.wr_cnt - w0, 0);
    access(1, 1, 1, 4'hf, 32'h4280, 32'hcafe_0004);
    check("dirty out", u_mem.mem[32'h4180], 32'h5a77_e425);
    check("store victim", u_mem.wr_cnt - w0, 1);
    access(0, 1, 1, 4'hf, 32'h4280, 0);
    check("store alloc", got, 32'hcafe_0004);
    check("store alloc hit", got_hit, 1);
  endtask
  initial begin
    repeat (20) @(negedge i_clock);
    i_reset_n = 1'b1;
    for (int i = 0; i < 64; i++) begin
      i_inval = 1'b1;
      i_inval_index = i[5:0];
      @(negedge i_clock);
    end
    i_inval = 1'b0;
    @(negedge i_clock);
    t_refill();
    t_uncached();
    t_write_thru();
    t_write_back();
    t_wb_merge();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    report_and_stop();
  end
endmodule // dcap_cache_tb_top

// ===== dcap_consts.svh
`ifndef DCAP_CONSTS_SVH
`define DCAP_CONSTS_SVH
// ----------------------------------------
// geometry and field positions
// ----------------------------------------
`define DCAP_ADDR_W 32
`define DCAP_DATA_W 32
`define DCAP_INDEX_W 6
`define DCAP_INDEX_LSB 2
`define DCAP_TAG_LSB 8
`define DCAP_TAG_W 24
`define DCAP_REFILL_MAX 4
`define DCAP_CNT_W 3
`endif

// ===== dcap_mem_model.sv
`timescale 1ns/1ns
// ----------
// external memory, slow and prompt acks in turn
// ----------
module dcap_mem_model (
  // clock
  input wire logic i_clock,
  // request
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [3:0] i_byte_en,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  // answer
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] ka;
  logic [31:0] w;
  int rd_cnt = 0;
  int wr_cnt = 0;
  int wait_cnt = 0;
  logic slow = 1'b0;
  initial o_ack = 1'b0;
  initial o_rdata = 32'h0;
  assign ka = {i_addr[31:2], 2'b00};
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'h5a5a_a5a5;
  endfunction
  always @(posedge i_clock) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack && wait_cnt < (slow ? 3 : 0)) begin
      wait_cnt <= wait_cnt + 1;
    end else if (i_req && !o_ack) begin
      wait_cnt <= 0;
      slow <= !slow;
      o_ack <= 1'b1;
      w = peek(ka);
      if (i_write) begin
        for (int b = 0; b < 4; b++) begin
          if (i_byte_en[b]) w[8*b +: 8] = i_wdata[8*b +: 8];
        end
        mem[ka] = w;
        wr_cnt++;
      end else begin
        o_rdata <= w;
        rd_cnt++;
      end
    end
  end
endmodule // dcap_mem_model

// ===== dcap_pkg.sv
package dcap_pkg;
  typedef enum logic [2:0] {
    DCAP_IDLE = 3'b000,
    DCAP_MERGE = 3'b001,
    DCAP_WBACK = 3'b010,
    DCAP_FILL = 3'b011,
    DCAP_UNC_RD = 3'b100,
    DCAP_MEM_WR = 3'b101
  } dcap_state_type;
endpackage
